//--- rtl/pin_state_regs.svh
`ifndef PIN_STATE_REGS_SVH
`define PIN_STATE_REGS_SVH
// Clock output selector codes
`define CKO_SEL_FLOAT0 2'h0
`define CKO_SEL_LOW 2'h1
`define CKO_SEL_CLOCK 2'h2
`define CKO_SEL_FLOAT3 2'h3
// Boot modes
`define BOOT_PARALLEL 2'h0
`define BOOT_SERIAL1 2'h1
`define BOOT_NAND 2'h2
`define BOOT_SERIAL3 2'h3
// Reset values
`define IO_HOLD_RST 1'b0
`define MODE_RST 4'h1
`endif

//--- rtl/pin_state_pkg.sv
package pin_state_pkg;
    typedef enum logic [3:0] {
        PM_RUN = 4'h1,
        PM_SLEEP = 4'h2,
        PM_SW_STANDBY_SELECT = 4'h4,
        PM_DEEP_STANDBY_SELECT = 4'h8
    } power_mode_t;
    typedef enum logic [1:0] {
        PIN_LIVE = 2'h0,
        PIN_HOLD = 2'h1,
        PIN_FLOAT = 2'h2,
        PIN_INPUT = 2'h3
    } pin_action_t;
endpackage

//--- rtl/pin_hold_group.sv
`timescale 1ns/10ps
// Per-group pad mux: live, held, float or input-only
module pin_hold_group #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic capture_in,
    input wire logic [1:0] action_in,
    input wire logic [WIDTH-1:0] live_out_in,
    input wire logic [WIDTH-1:0] live_oe_in,
    input wire logic [WIDTH-1:0] force_input_in,
    input wire logic [WIDTH-1:0] input_float_in,
    output logic [WIDTH-1:0] pad_out,
    output logic [WIDTH-1:0] pad_oe_out
);
    import pin_state_pkg::*;
    logic [WIDTH-1:0] hold_val_reg;
    logic [WIDTH-1:0] hold_oe_reg;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hold_val_reg <= '0;
            hold_oe_reg <= '0;
        end else if (capture_in) begin
            hold_val_reg <= live_out_in;
            hold_oe_reg <= live_oe_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pad_out <= '0;
            pad_oe_out <= '0;
        end else begin
            case (pin_action_t'(action_in))
                PIN_LIVE: begin
                    pad_out <= live_out_in;
                    pad_oe_out <= live_oe_in;
                end
                PIN_HOLD: begin
                    pad_out <= hold_val_reg;
                    pad_oe_out <= hold_oe_reg & ~force_input_in
                        & ~input_float_in;
                end
                default: begin
                    pad_out <= '0;
                    pad_oe_out <= '0;
                end
            endcase
        end
    end
endmodule

//--- rtl/pin_state_ctrl.sv
`timescale 1ns/10ps
`include "pin_state_regs.svh"
module pin_state_ctrl #(
    parameter int PERIPH_W = 16,
    parameter int MSTBY_W = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sleep_exec_in,
    input wire logic standby_select_in,
    input wire logic deep_select_in,
    input wire logic wake_in,
    input wire logic deep_wake_in,
    input wire logic io_hold_clear_in,
    input wire logic ext_bus_hold_enable_in,
    input wire logic [1:0] boot_mode_in,
    input wire logic [1:0] clock_mode_in,
    input wire logic [1:0] clock_out_pin_sel_in,
    input wire logic mem_bus_float_sel_in,
    input wire logic dram_ctrl_float_sel_in,
    input wire logic periph_pin_float_sel_in,
    input wire logic rtc_clock_select_in,
    input wire logic rtc_osc_enable_in,
    input wire logic [MSTBY_W-1:0] module_standby_in,
    input wire logic [MSTBY_W-1:0] module_init_on_standby_select_in,
    input wire logic [PERIPH_W-1:0] periph_out_in,
    input wire logic [PERIPH_W-1:0] periph_oe_in,
    input wire logic [PERIPH_W-1:0] periph_dir_in_in,
    input wire logic [PERIPH_W-1:0] wake_pin_en_in,
    input wire logic [PERIPH_W-1:0] boot_pin_mask_parallel_in,
    input wire logic [PERIPH_W-1:0] boot_pin_mask_nand_in,
    input wire logic [PERIPH_W-1:0] boot_pin_mask_serial_in,
    input wire logic [PERIPH_W-1:0] periph_pin_module_in,
    input wire logic bus_clock_in,
    output pin_state_pkg::power_mode_t power_mode_out,
    output logic io_hold_out,
    output logic [PERIPH_W-1:0] periph_pad_out,
    output logic [PERIPH_W-1:0] periph_pad_oe_out,
    output logic bus_clock_out,
    output logic bus_clock_oe_out,
    output logic mem_bus_oe_out,
    output logic dram_ctrl_oe_out,
    output logic data_bus_oe_out,
    output logic data_bus_in_en_out,
    output logic main_crystal_out,
    output logic main_crystal_oe_out,
    output logic main_crystal_in_en_out,
    output logic aux_crystal_oe_out,
    output logic fixed_float_out,
    output logic usb_data_hold_out,
    output logic usb_data_float_out,
    output logic rtc_crystal_out,
    output logic rtc_crystal_oe_out,
    output logic rtc_crystal_in_en_out,
    output logic periph_in_en_out,
    output logic sys_in_en_out,
    output logic irq_rx_in_en_out
);
    import pin_state_pkg::*;

    // ----------------------------------------
    // Mode tracking
    // ----------------------------------------
    power_mode_t mode_reg;
    power_mode_t mode_next;
    logic io_hold_reg;
    logic early_rel_reg;
    logic bus_clock_hold_reg;
    logic in_standby_select;
    logic in_deep;
    logic capture;

    assign in_standby_select = (mode_reg == PM_SW_STANDBY_SELECT) || (mode_reg == PM_DEEP_STANDBY_SELECT);
    assign in_deep = (mode_reg == PM_DEEP_STANDBY_SELECT);
    assign capture = (mode_next == PM_SW_STANDBY_SELECT || mode_next == PM_DEEP_STANDBY_SELECT)
        && !in_standby_select;

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            PM_RUN: begin
                if (sleep_exec_in) begin
                    if (!standby_select_in)
                        mode_next = PM_SLEEP;
                    else if (deep_select_in)
                        mode_next = PM_DEEP_STANDBY_SELECT;
                    else
                        mode_next = PM_SW_STANDBY_SELECT;
                end
            end
            PM_SLEEP, PM_SW_STANDBY_SELECT: begin
                if (wake_in)
                    mode_next = PM_RUN;
            end
            PM_DEEP_STANDBY_SELECT: begin
                if (deep_wake_in)
                    mode_next = PM_RUN;
            end
            default: mode_next = PM_RUN;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in)
            mode_reg <= power_mode_t'(`MODE_RST);
        else
            mode_reg <= mode_next;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in)
            io_hold_reg <= `IO_HOLD_RST;
        else if (in_deep && deep_wake_in)
            io_hold_reg <= 1'b1;
        else if (io_hold_clear_in)
            io_hold_reg <= 1'b0;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in)
            early_rel_reg <= 1'b0;
        else if (in_deep && deep_wake_in)
            early_rel_reg <= !ext_bus_hold_enable_in;
        else if (io_hold_clear_in)
            early_rel_reg <= 1'b0;
    end

    function automatic logic [PERIPH_W-1:0] boot_mask(input logic [1:0] bm);
        case (bm)
            `BOOT_PARALLEL: boot_mask = boot_pin_mask_parallel_in;
            `BOOT_NAND: boot_mask = boot_pin_mask_nand_in;
            default: boot_mask = boot_pin_mask_serial_in;
        endcase
    endfunction

    // ----------------------------------------
    // Peripheral pin groups
    // ----------------------------------------
    logic [1:0] periph_action;
    logic [PERIPH_W-1:0] live_out;
    logic [PERIPH_W-1:0] live_oe;
    logic [PERIPH_W-1:0] force_in;
    logic [PERIPH_W-1:0] mstby_default;
    logic [PERIPH_W-1:0] mstby_hold;
    logic [PERIPH_W-1:0] rel_mask;
    logic [PERIPH_W-1:0] mhold_val_reg;
    logic [PERIPH_W-1:0] mhold_oe_reg;
    logic [MSTBY_W-1:0] mstby_prev_reg;

    always_comb begin
        mstby_default = '0;
        mstby_hold = '0;
        for (int i = 0; i < PERIPH_W; i++) begin
            if (module_standby_in[periph_pin_module_in[i] ? 1 : 0]) begin
                if (module_init_on_standby_select_in[periph_pin_module_in[i] ? 1 : 0])
                    mstby_default[i] = 1'b1;
                else
                    mstby_hold[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mstby_prev_reg <= '0;
            mhold_val_reg <= '0;
            mhold_oe_reg <= '0;
        end else begin
            mstby_prev_reg <= module_standby_in;
            for (int i = 0; i < PERIPH_W; i++) begin
                if (!mstby_hold[i]) begin
                    mhold_val_reg[i] <= periph_out_in[i];
                    mhold_oe_reg[i] <= periph_oe_in[i];
                end
            end
        end
    end

    assign rel_mask = early_rel_reg ? boot_mask(boot_mode_in) : '0;
    assign live_out = (periph_out_in & ~mstby_default & ~mstby_hold)
        | (mhold_val_reg & mstby_hold);
    assign live_oe = (periph_oe_in & ~mstby_default & ~mstby_hold)
        | (mhold_oe_reg & mstby_hold);
    assign force_in = in_deep ? wake_pin_en_in : '0;

    always_comb begin
        if (in_standby_select)
            periph_action = periph_pin_float_sel_in ? PIN_FLOAT : PIN_HOLD;
        else if (io_hold_reg)
            periph_action = PIN_HOLD;
        else
            periph_action = PIN_LIVE;
    end

    logic [PERIPH_W-1:0] grp_out;
    logic [PERIPH_W-1:0] grp_oe;

    pin_hold_group #(
        .WIDTH(PERIPH_W)
    ) u_periph (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .capture_in(capture),
        .action_in(periph_action),
        .live_out_in(live_out),
        .live_oe_in(live_oe),
        .force_input_in(force_in),
        .input_float_in(in_standby_select ? periph_dir_in_in : '0),
        .pad_out(grp_out),
        .pad_oe_out(grp_oe)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            periph_pad_out <= '0;
            periph_pad_oe_out <= '0;
        end else begin
            periph_pad_out <= (grp_out & ~rel_mask) | (live_out & rel_mask);
            periph_pad_oe_out <= (grp_oe & ~rel_mask) | (live_oe & rel_mask);
        end
    end

    // ----------------------------------------
    // Fixed pins
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in)
            bus_clock_hold_reg <= 1'b0;
        else if (capture)
            bus_clock_hold_reg <= bus_clock_in;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bus_clock_out <= 1'b0;
            bus_clock_oe_out <= 1'b0;
        end else if (!in_standby_select) begin
            bus_clock_out <= bus_clock_in;
            bus_clock_oe_out <= 1'b1;
        end else begin
            case (clock_out_pin_sel_in)
                `CKO_SEL_LOW: begin
                    bus_clock_out <= in_deep ? bus_clock_hold_reg : 1'b0;
                    bus_clock_oe_out <= 1'b1;
                end
                `CKO_SEL_CLOCK: begin
                    bus_clock_out <= in_deep ? bus_clock_hold_reg
                        : bus_clock_in;
                    bus_clock_oe_out <= 1'b1;
                end
                `CKO_SEL_FLOAT0: begin
                    bus_clock_out <= bus_clock_hold_reg;
                    bus_clock_oe_out <= in_deep;
                end
                default: begin
                    bus_clock_out <= 1'b0;
                    bus_clock_oe_out <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mem_bus_oe_out <= 1'b0;
            dram_ctrl_oe_out <= 1'b0;
            data_bus_oe_out <= 1'b0;
            data_bus_in_en_out <= 1'b0;
            main_crystal_out <= 1'b0;
            main_crystal_oe_out <= 1'b0;
            main_crystal_in_en_out <= 1'b0;
            aux_crystal_oe_out <= 1'b0;
            fixed_float_out <= 1'b0;
            usb_data_hold_out <= 1'b0;
            usb_data_float_out <= 1'b0;
            periph_in_en_out <= 1'b0;
            sys_in_en_out <= 1'b0;
            irq_rx_in_en_out <= 1'b0;
        end else begin
            mem_bus_oe_out <= !in_standby_select || mem_bus_float_sel_in;
            dram_ctrl_oe_out <= !in_standby_select || dram_ctrl_float_sel_in;
            data_bus_oe_out <= !in_standby_select;
            data_bus_in_en_out <= !in_standby_select;
            main_crystal_out <= 1'b0;
            main_crystal_oe_out <= 1'b1;
            aux_crystal_oe_out <= 1'b1;
            if (!in_standby_select)
                main_crystal_in_en_out <= 1'b1;
            else if (clock_mode_in[0])
                main_crystal_in_en_out <= 1'b0;
            else
                main_crystal_in_en_out <= !in_deep || rtc_clock_select_in;
            fixed_float_out <= in_standby_select;
            usb_data_hold_out <= mode_reg == PM_SW_STANDBY_SELECT;
            usb_data_float_out <= in_deep;
            periph_in_en_out <= !in_standby_select;
            sys_in_en_out <= 1'b1;
            irq_rx_in_en_out <= !in_deep;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rtc_crystal_out <= 1'b1;
            rtc_crystal_oe_out <= 1'b0;
            rtc_crystal_in_en_out <= 1'b0;
        end else begin
            rtc_crystal_out <= 1'b1;
            rtc_crystal_oe_out <= 1'b1;
            rtc_crystal_in_en_out <= rtc_osc_enable_in;
        end
    end

    assign power_mode_out = mode_reg;
    assign io_hold_out = io_hold_reg;
endmodule

//--- verification/board_pins.sv
`timescale 1ns/10ps
// ----------------------------------------
// Board side of the peripheral pads
// ----------------------------------------
module board_pins #(
    parameter int W = 16
) (
    input wire logic clk_in,
    input wire logic [W-1:0] pad_in,
    input wire logic [W-1:0] oe_in,
    output logic clk_src_out,
    output logic [W-1:0] level_out
);
    logic div_reg = 1'h0;
    // No pulls on the board: a released line wanders every cycle
    assign level_out = (pad_in & oe_in) | ({W{div_reg}} & ~oe_in);
    assign clk_src_out = div_reg;
    always @(posedge clk_in) begin
        div_reg <= ~div_reg;
    end
endmodule

//--- verification/pin_state_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for pad state control
// ----------------------------------------
module pin_state_assertions
import pin_state_pkg::*;
#(
    parameter int PERIPH_W = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sleep_exec_in,
    input wire logic standby_select_in,
    input wire logic deep_select_in,
    input wire logic deep_wake_in,
    input wire logic io_hold_clear_in,
    input wire logic [1:0] clock_out_pin_sel_in,
    input wire logic mem_bus_float_sel_in,
    input wire logic [PERIPH_W-1:0] wake_pin_en_in,
    input wire power_mode_t power_mode_out,
    input wire logic io_hold_out,
    input wire logic [PERIPH_W-1:0] periph_pad_oe_out,
    input wire logic bus_clock_out,
    input wire logic bus_clock_oe_out,
    input wire logic mem_bus_oe_out,
    input wire logic data_bus_oe_out,
    input wire logic fixed_float_out,
    input wire logic usb_data_float_out,
    input wire logic sys_in_en_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic sw, deep, standby_select;
    assign sw = power_mode_out == PM_SW_STANDBY_SELECT;
    assign deep = power_mode_out == PM_DEEP_STANDBY_SELECT;
    assign standby_select = sw || deep;
    sequence standby_select_req_s;
        power_mode_out == PM_RUN && sleep_exec_in && standby_select_in;
    endsequence
    sequence deep_wake_s;
        deep && deep_wake_in;
    endsequence
    deep_entry_a: assert property (standby_select_req_s ##0 deep_select_in |=> deep)
        else $error("deep standby not entered");
    sw_entry_a: assert property (standby_select_req_s ##0 !deep_select_in |=> sw)
        else $error("software standby not entered");
    clock_sw_a: assert property (sw |=> bus_clock_oe_out ==
        ($past(clock_out_pin_sel_in) inside {2'h1, 2'h2}))
        else $error("clock pin drive wrong");
    clock_low_a: assert property (sw && clock_out_pin_sel_in == 2'h1
        |=> bus_clock_oe_out && !bus_clock_out) else $error("clock pin not low");
    clock_deep_a: assert property (deep |=> bus_clock_oe_out ==
        ($past(clock_out_pin_sel_in) != 2'h3)) else $error("deep clock pin");
    mem_float_a: assert property (standby_select |=> mem_bus_oe_out ==
        $past(mem_bus_float_sel_in)) else $error("memory bus drive wrong");
    pad_groups_a: assert property (standby_select |=> !data_bus_oe_out &&
        fixed_float_out && sys_in_en_out) else $error("standby pad groups");
    usb_float_a: assert property (standby_select |=> usb_data_float_out ==
        ($past(power_mode_out) == PM_DEEP_STANDBY_SELECT)) else $error("usb float");
    wake_input_a: assert property (deep && $past(deep) |=>
        (periph_pad_oe_out & $past(wake_pin_en_in, 2)) == '0)
        else $error("wake pin driven");
    deep_wake_a: assert property (deep_wake_s |=>
        power_mode_out == PM_RUN && io_hold_out) else $error("no hold on wake");
    hold_clear_a: assert property (io_hold_out && !deep_wake_in |=>
        io_hold_out == !$past(io_hold_clear_in)) else $error("hold release");
endmodule
bind pin_state_ctrl pin_state_assertions #(.PERIPH_W(PERIPH_W)) chk (.*);

//--- verification/tb_powerdown_pin_state_control.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bench for pad state control
// ----------------------------------------
module tb_powerdown_pin_state_control;
import pin_state_pkg::*;
`define CK(a, b) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
        errors++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
end
    logic clk_in = '0, rst_in = '1, sleep_exec_in = '0, wake_in = '0;
    logic standby_select_in = '0, deep_select_in = '0, deep_wake_in = '0;
    logic io_hold_clear_in = '0, ext_bus_hold_enable_in = '0;
    logic mem_bus_float_sel_in = '0, dram_ctrl_float_sel_in = '0;
    logic periph_pin_float_sel_in = '0, rtc_clock_select_in = '0;
    logic rtc_osc_enable_in = '0, bus_clock_in, fl, rck;
    logic [1:0] boot_mode_in = '0, clock_mode_in = '0;
    logic [1:0] clock_out_pin_sel_in = '0;
    logic [7:0] module_standby_in = '0, module_init_on_standby_select_in = '0;
    logic [15:0] periph_out_in = '0, periph_oe_in = 16'h00ff;
    logic [15:0] periph_dir_in_in = 16'hff00, wake_pin_en_in = 16'h0003;
    logic [15:0] boot_pin_mask_parallel_in = 16'h0030;
    logic [15:0] boot_pin_mask_nand_in = 16'h00c0;
    logic [15:0] boot_pin_mask_serial_in = 16'h000c;
    logic [15:0] periph_pin_module_in = 16'hf0f0, live = 16'h5a3c;
    logic [15:0] periph_pad_out, periph_pad_oe_out, level, mask;
    power_mode_t power_mode_out;
    logic io_hold_out, bus_clock_out, bus_clock_oe_out, mem_bus_oe_out;
    logic dram_ctrl_oe_out, data_bus_oe_out, data_bus_in_en_out;
    logic main_crystal_out, main_crystal_oe_out, main_crystal_in_en_out;
    logic aux_crystal_oe_out, fixed_float_out, usb_data_hold_out;
    logic usb_data_float_out, rtc_crystal_out, rtc_crystal_oe_out;
    logic rtc_crystal_in_en_out, periph_in_en_out, sys_in_en_out;
    logic irq_rx_in_en_out;
    int errors = 0, total_checks = 0;

    always #2.5 clk_in = ~clk_in;

    board_pins BRD (.clk_in(clk_in), .pad_in(periph_pad_out),
        .oe_in(periph_pad_oe_out), .clk_src_out(bus_clock_in),
        .level_out(level));
    pin_state_ctrl DUT (.*);

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One-cycle request, sampled after the answering edge
    task automatic pulse(input int k);
        @(posedge clk_in);
        case (k)
            0: sleep_exec_in <= 1'h1;
            1: wake_in <= 1'h1;
            2: deep_wake_in <= 1'h1;
            default: io_hold_clear_in <= 1'h1;
        endcase
        @(posedge clk_in);
        {sleep_exec_in, wake_in, deep_wake_in, io_hold_clear_in} <= 4'h0;
        #1;
    endtask

    task automatic wait_mode(input power_mode_t m);
        for (int n = 0; n < 8 && power_mode_out !== m; n++) begin
            @(posedge clk_in);
            #1;
        end
        `CK(power_mode_out, m)
        if (power_mode_out !== m)
            end_sim();
    endtask

    task automatic edges(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'h0;
        edges(1);
        `CK(power_mode_out, PM_RUN)
        `CK(io_hold_out, 1'h0)
        @(posedge clk_in);
        periph_out_in <= live;
        pulse(0);
        wait_mode(PM_SLEEP);
        @(posedge clk_in);
        periph_out_in <= ~live;
        edges(2);
        `CK(level & 16'h00ff, ~live & 16'h00ff)
        pulse(1);
        wait_mode(PM_RUN);
        @(posedge clk_in);
        module_standby_in <= 8'h03;
        module_init_on_standby_select_in <= 8'h01;
        edges(3);
        @(posedge clk_in);
        periph_out_in <= live;
        edges(3);
        `CK(periph_pad_oe_out, 16'h00f0)
        `CK(level & 16'h00f0, ~live & 16'h00f0)
        @(posedge clk_in);
        module_standby_in <= 8'h00;
        // Every selector code, boot mode and clock mode in both standbys
        for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 2; d++) begin
                fl = c[0] & ~d[0];
                rck = c[1];
                @(posedge clk_in);
                periph_out_in <= live;
                {clock_out_pin_sel_in, clock_mode_in, boot_mode_in} <=
                    {3{c[1:0]}};
                {mem_bus_float_sel_in, dram_ctrl_float_sel_in} <=
                    {c[0], ~c[0]};
                {periph_pin_float_sel_in, rtc_clock_select_in} <= {fl, rck};
                rtc_osc_enable_in <= c[0];
                ext_bus_hold_enable_in <= c == 3;
                {standby_select_in, deep_select_in} <= {1'h1, d[0]};
                edges(3);
                pulse(0);
                wait_mode(d ? PM_DEEP_STANDBY_SELECT : PM_SW_STANDBY_SELECT);
                // Pads sit two registers behind the mode
                edges(2);
                mask = fl ? 16'h0000 : d ? 16'h00fc : 16'h00ff;
                `CK(periph_pad_oe_out, mask)
                `CK(bus_clock_oe_out, d ? c != 3 : c == 1 || c == 2)
                `CK(mem_bus_oe_out, c[0])
                `CK(dram_ctrl_oe_out, ~c[0])
                `CK({data_bus_oe_out, data_bus_in_en_out}, 2'h0)
                `CK({fixed_float_out, periph_in_en_out}, 2'h2)
                `CK(sys_in_en_out, 1'h1)
                `CK({usb_data_hold_out, usb_data_float_out}, {~d[0], d[0]})
                `CK(irq_rx_in_en_out, ~d[0])
                `CK({main_crystal_oe_out, aux_crystal_oe_out}, 2'h3)
                if (!rck) `CK(main_crystal_out, 1'h0)
                `CK(main_crystal_in_en_out, ~c[0] & (~d[0] | rck))
                `CK({rtc_crystal_oe_out, rtc_crystal_in_en_out}, {1'h1, c[0]})
                if (!c[0]) `CK(rtc_crystal_out, 1'h1)
                if (!d) begin
                    @(posedge clk_in);
                    deep_select_in <= 1'h1;
                    pulse(0);
                    `CK(power_mode_out, PM_SW_STANDBY_SELECT)
                end
                // Live values move; held pads must not follow
                @(posedge clk_in);
                periph_out_in <= ~live;
                edges(2);
                if (!fl) `CK(level & 16'h00fc, live & 16'h00fc)
                pulse(d ? 2 : 1);
                wait_mode(PM_RUN);
                `CK(io_hold_out, d[0])
                edges(2);
                mask = c == 3 ? 16'h0000 : c == 0 ? boot_pin_mask_parallel_in
                    : c == 2 ? boot_pin_mask_nand_in : boot_pin_mask_serial_in;
                mask = (~live & mask | live & ~mask) & 16'h00fc;
                if (d) `CK(level & 16'h00fc, mask)
                if (d) begin
                    pulse(3);
                    `CK(io_hold_out, 1'h0)
                    edges(2);
                    `CK(level & 16'h00fc, ~live & 16'h00fc)
                end
            end
        end
        end_sim();
    end
endmodule
